// *** rtl/sew_pkg.sv ***
// shared constants and types of the serial eeprom slave
package sew_pkg;

    // ****************************************
    // select byte layout
    // ****************************************
    localparam int SEL_TYPE_LSB = 4;
    localparam int SEL_CS_HI = 3;
    localparam int SEL_CS_LO = 2;
    localparam int SEL_BLOCK = 1;
    localparam int SEL_RW = 0;
    // arbitrary value, not a real part code
    localparam logic [3:0] DEV_TYPE_DEF = 4'h6;

    // ****************************************
    // protection pointer byte
    // ****************************************
    localparam logic [8:0] PTR_ADDR = 9'h1FF;
    localparam int PTR_FLAG_BIT = 2;
    localparam int PTR_BOUND_LSB = 3;

    // ****************************************
    // array and row geometry
    // ****************************************
    localparam int MEM_BYTES = 512;
    localparam int ROW_BYTES = 8;
    localparam int FIFO_DEPTH = 4;

    // ****************************************
    // program cycle timing
    // ****************************************
    localparam int CLK_KHZ = 100000;
    localparam int TW_MS = 10;
    localparam int TW_LONG_MS = 20;
    localparam int TW_CYC = TW_MS * CLK_KHZ;
    localparam int TW_LONG_CYC = TW_LONG_MS * CLK_KHZ;

    // ****************************************
    // byte phases and states
    // ****************************************
    localparam logic [1:0] PH_SEL = 2'h0;
    localparam logic [1:0] PH_ADDR = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
    } sew_wr_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RECV = 6'h02,
        ST_ACK = 6'h04,
        ST_FLUSH = 6'h08,
        ST_WALK = 6'h10,
        ST_WAIT = 6'h20
    } sew_state_t;

endpackage

// *** rtl/sew_fifo.sv ***
// small valid/ready fifo between the bus side and the write latches
`timescale 1ns/100ps
module sew_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_r;
    logic [PW-1:0] rd_r;
    logic [CW-1:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != FULL);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (clk_en && push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

endmodule

// *** rtl/sew_top.sv ***
// two-wire eeprom slave with write modes and block write protection
//
// How it works
// - upper select nibble must equal type code
// - next two select bits match chip selects
// - seventh select bit picks 256-byte block
// - last select bit: one read, zero write
// - matching select byte acknowledged at ninth bit
// - write_mode high multibyte, low page, dynamic
// - write select then byte address, both acknowledged
// - write_inhibit high leaves array unchanged
// - single byte write works in either mode
// - multibyte: any start, up to eight bytes
// - multibyte cycle 10 ms, 20 ms across rows
// - page mode takes up to eight row bytes
// - page mode increments low three bits only
// - stop launches program cycle, bus ignored meanwhile
// - busy device withholds select ack for polling
// - protection covers upper block only
// - protect from boundary to top when enabled
// - pointer byte: five boundary bits, low zeros
// - protect pin low leaves pointer byte ordinary
`timescale 1ns/100ps
module sew_top
    import sew_pkg::*;
#(
    parameter logic [3:0] TYPE_CODE = sew_pkg::DEV_TYPE_DEF,
    parameter int PROG_CYC = sew_pkg::TW_CYC,
    parameter int PROG_LONG_CYC = sew_pkg::TW_LONG_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic chip_select_low_bit,
    input wire logic chip_select_high_bit,
    input wire logic write_mode,
    input wire logic write_inhibit,
    input wire logic protect_enable,
    output logic busy
);
    import sew_pkg::*;

    // ****************************************
    // reset release and input synchronisers
    // ****************************************
    logic [1:0] rst_q;
    logic rst_n;
    logic [5:0] pin_m;
    logic [5:0] pin_s;
    logic scl_d;
    logic sda_d;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_q <= 2'h0;
        end else if (clk_en) begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // slow pins and the bus lines all come from outside this clock
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_m <= 6'h03;
            pin_s <= 6'h03;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (clk_en) begin
            pin_m <= {protect_enable, write_inhibit, write_mode,
                      chip_select_high_bit, sda_in, scl};
            pin_s <= pin_m;
            scl_d <= pin_s[0];
            sda_d <= pin_s[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic cs_lo_m;
    logic cs_lo_s;
    assign scl_s = pin_s[0];
    assign sda_s = pin_s[1];
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign bus_start = scl_s && scl_d && sda_d && !sda_s;
    assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_lo_m <= 1'b0;
            cs_lo_s <= 1'b0;
        end else if (clk_en) begin
            cs_lo_m <= chip_select_low_bit;
            cs_lo_s <= cs_lo_m;
        end
    end

    // ****************************************
    // byte receiver and acknowledge
    // ****************************************
    sew_state_t state_r;
    logic [1:0] phase_r;
    logic [3:0] bit_r;
    logic [7:0] shift_r;
    logic block_r;
    logic [7:0] addr_r;
    logic data_seen_r;
    logic sda_oe_r;
    logic sda_out_r;
    logic sel_match;
    logic fifo_in_ready;
    logic push;
    sew_wr_t push_ent;
    logic [7:0] addr_nxt;
    logic span_r;
    logic [3:0] walk_r;
    logic [20:0] tmr_r;
    logic fifo_empty;

    assign sel_match = (shift_r[7:SEL_TYPE_LSB] == TYPE_CODE)
        && (shift_r[SEL_CS_HI] == pin_s[2])
        && (shift_r[SEL_CS_LO] == cs_lo_s);

    // page mode wraps inside the row, multibyte runs through the block
    always_comb begin
        if (pin_s[3]) begin
            addr_nxt = addr_r + 8'h01;
        end else begin
            addr_nxt = {addr_r[7:3], addr_r[2:0] + 3'h1};
        end
    end

    assign push_ent = '{addr: {block_r, addr_r}, data: shift_r};
    assign push = (state_r == ST_RECV) && scl_fall && (bit_r == 4'h8)
        && (phase_r == PH_DATA) && fifo_in_ready;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            phase_r <= PH_SEL;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            block_r <= 1'b0;
            addr_r <= 8'h00;
            data_seen_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (clk_en) begin
            case (state_r)
                ST_IDLE, ST_RECV, ST_ACK: begin
                    if (bus_stop && data_seen_r) begin
                        state_r <= ST_FLUSH;
                        sda_oe_r <= 1'b0;
                    end else if (bus_stop) begin
                        state_r <= ST_IDLE;
                        sda_oe_r <= 1'b0;
                    end else if (bus_start) begin
                        state_r <= ST_RECV;
                        phase_r <= PH_SEL;
                        bit_r <= 4'h0;
                        sda_oe_r <= 1'b0;
                    end else if (state_r == ST_RECV) begin
                        if (scl_rise && bit_r != 4'h8) begin
                            shift_r <= {shift_r[6:0], sda_s};
                            bit_r <= bit_r + 4'h1;
                        end else if (scl_fall && bit_r == 4'h8) begin
                            case (phase_r)
                                PH_SEL: begin
                                    if (sel_match) begin
                                        sda_oe_r <= 1'b1;
                                        state_r <= ST_ACK;
                                        block_r <= shift_r[SEL_BLOCK];
                                    end else begin
                                        state_r <= ST_IDLE;
                                    end
                                    // reads are not served beyond the ack
                                    phase_r <= shift_r[SEL_RW] ?
                                        PH_SEL : PH_ADDR;
                                end
                                PH_ADDR: begin
                                    addr_r <= shift_r;
                                    sda_oe_r <= 1'b1;
                                    state_r <= ST_ACK;
                                    phase_r <= PH_DATA;
                                end
                                default: begin
                                    // a full fifo withholds the ack
                                    if (fifo_in_ready) begin
                                        sda_oe_r <= 1'b1;
                                        state_r <= ST_ACK;
                                        addr_r <= addr_nxt;
                                        data_seen_r <= 1'b1;
                                    end else begin
                                        state_r <= ST_IDLE;
                                    end
                                end
                            endcase
                        end
                    end else if (state_r == ST_ACK && scl_fall) begin
                        sda_oe_r <= 1'b0;
                        bit_r <= 4'h0;
                        state_r <= (phase_r == PH_SEL) ? ST_IDLE : ST_RECV;
                    end
                end
                ST_FLUSH: begin
                    // bus is deaf until the program cycle ends
                    if (fifo_empty) begin
                        state_r <= ST_WALK;
                    end
                end
                ST_WALK: begin
                    if (walk_r == 4'(ROW_BYTES - 1)) begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (tmr_r == 21'h000000) begin
                        state_r <= ST_IDLE;
                        data_seen_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // fifo into the row latches
    // ****************************************
    logic fifo_out_valid;
    logic fifo_out_ready;
    sew_wr_t fifo_out;
    logic [16:0] fifo_out_bits;

    // the latch loader stalls outside collect and flush phases
    assign fifo_out_ready = (state_r != ST_WALK) && (state_r != ST_WAIT);
    assign fifo_empty = !fifo_out_valid;
    assign fifo_out = sew_wr_t'(fifo_out_bits);

    sew_fifo #(
        .WIDTH($bits(sew_wr_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_ent),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_bits)
    );

    logic load;
    logic [ROW_BYTES-1:0] lat_vld_r;
    sew_wr_t lat_r [ROW_BYTES];
    logic have_first_r;
    logic [5:0] first_row_r;
    logic walk_end;

    assign load = fifo_out_valid && fifo_out_ready;
    assign walk_end = (state_r == ST_WAIT) && (tmr_r == 21'h000000);

    genvar gi;
    generate
        for (gi = 0; gi < ROW_BYTES; gi++) begin : g_lat
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    lat_vld_r[gi] <= 1'b0;
                    lat_r[gi] <= '0;
                end else if (clk_en) begin
                    if (load && fifo_out.addr[2:0] == 3'(gi)) begin
                        lat_vld_r[gi] <= 1'b1;
                        lat_r[gi] <= fifo_out;
                    end else if (walk_end) begin
                        lat_vld_r[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // a multibyte burst crossing rows doubles the cycle time
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            have_first_r <= 1'b0;
            first_row_r <= 6'h00;
            span_r <= 1'b0;
        end else if (clk_en) begin
            if (walk_end) begin
                have_first_r <= 1'b0;
                span_r <= 1'b0;
            end else if (load && !have_first_r) begin
                have_first_r <= 1'b1;
                first_row_r <= fifo_out.addr[7:2];
            end else if (load && fifo_out.addr[7:2] != first_row_r
                         && pin_s[3]) begin
                span_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // array program walk with protection
    // ****************************************
    logic [7:0] mem_r [MEM_BYTES];
    logic [7:0] ptr_byte;
    sew_wr_t walk_ent;
    logic walk_guard;

    assign ptr_byte = mem_r[PTR_ADDR];
    assign walk_ent = lat_r[walk_r[2:0]];

    // pointer low bits are assumed zero, only the upper five compare
    assign walk_guard = pin_s[5]
        && !ptr_byte[PTR_FLAG_BIT]
        && walk_ent.addr[8]
        && (walk_ent.addr[7:PTR_BOUND_LSB] >=
            ptr_byte[7:PTR_BOUND_LSB]);

    always_ff @(posedge core_clk) begin
        if (clk_en && state_r == ST_WALK && lat_vld_r[walk_r[2:0]]
            && !pin_s[4] && !walk_guard) begin
            mem_r[walk_ent.addr] <= walk_ent.data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            walk_r <= 4'h0;
            tmr_r <= 21'h000000;
        end else if (clk_en) begin
            if (state_r == ST_WALK) begin
                walk_r <= walk_r + 4'h1;
                tmr_r <= span_r ? 21'(PROG_LONG_CYC - ROW_BYTES - 1)
                                : 21'(PROG_CYC - ROW_BYTES - 1);
            end else begin
                walk_r <= 4'h0;
                if (state_r == ST_WAIT && tmr_r != 21'h000000) begin
                    tmr_r <= tmr_r - 21'h000001;
                end
            end
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out_r <= 1'b0;
            busy <= 1'b0;
        end else if (clk_en) begin
            sda_out_r <= 1'b0;
            busy <= (state_r == ST_FLUSH) || (state_r == ST_WALK)
                || (state_r == ST_WAIT && tmr_r != 21'h000000);
        end
    end

    assign sda_oe = sda_oe_r;
    assign sda_out = sda_out_r;

endmodule

// *** verification/sew_top_properties.sv ***
// port-level concurrent checks of the eeprom slave
`timescale 1ns/100ps
module sew_checker #(
    parameter int PROG_CYC = 200,
    parameter int PROG_LONG_CYC = 400
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic busy
);
    // ****
    // busy length counter
    // ****
    logic [31:0] busy_cnt_r;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt_r <= '0;
        end else begin
            busy_cnt_r <= busy ? busy_cnt_r + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    // ****
    // acknowledge timing
    // ****
    // open drain: the data pin may only ever pull low
    AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
        else $error("sda output level not low");
    // an edge while scl is high would look like start or stop
    AST_OE_EDGE_SCL_LOW: assert property (
        $changed(sda_oe) |-> !scl)
        else $error("ack edge while scl high");
    AST_ACK_HOLDS: assert property ($rose(sda_oe) |=> sda_oe [*8])
        else $error("ack dropped inside ninth bit");
    AST_ACK_ENDS: assert property (
        $rose(sda_oe) |-> ##[9:20] !sda_oe)
        else $error("ack not released after ninth bit");
    // ****
    // program cycle
    // ****
    AST_QUIET_BUSY: assert property (
        busy && $past(busy) |-> !sda_oe)
        else $error("bus answered while programming");
    AST_BUSY_ON_STOP: assert property ($rose(busy) |-> scl && sda_in)
        else $error("program started without stop");
    AST_BUSY_MIN: assert property (
        $fell(busy) |-> busy_cnt_r >= 32'(PROG_CYC / 2))
        else $error("program cycle too short");
    AST_BUSY_MAX: assert property (
        $fell(busy) |-> busy_cnt_r <= 32'(PROG_LONG_CYC + 40))
        else $error("program cycle too long");
    COV_ACK: cover property ($rose(sda_oe));
    COV_PROG: cover property ($rose(busy));
    COV_LONG: cover property ($fell(busy) && busy_cnt_r > 32'(PROG_CYC + 40));
endmodule

bind sew_top sew_checker #(
    .PROG_CYC(PROG_CYC),
    .PROG_LONG_CYC(PROG_LONG_CYC)
) u_chk (
    .core_clk(core_clk), .nrst(nrst), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy)
);

// *** verification/sew_master.sv ***
// behavioural two-wire bus master facing the eeprom slave
`timescale 1ns/100ps
module sew_master (
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    // ****
    // bit and frame tasks
    // ****
    // clock stands high and data released between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // data moves well inside the low phase, so no false start or stop
    task automatic put_bit(input logic b, output logic r);
        #16;
        sda_drv = b;
        #46;
        scl = 1'b1;
        #31;
        r = sda;
        #32;
        scl = 1'b0;
    endtask
    // waits out the slave's ack release before raising the clock
    task automatic start_c();
        #62;
        sda_drv = 1'b1;
        #62;
        scl = 1'b1;
        #62;
        sda_drv = 1'b0;
        #62;
        scl = 1'b0;
    endtask
    task automatic stop_c();
        #62;
        sda_drv = 1'b0;
        #62;
        scl = 1'b1;
        #62;
        sda_drv = 1'b1;
        #62;
    endtask
    // msb first, then releases the line for the ninth bit
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        int i;
        for (i = 7; i >= 0; i--) begin
            put_bit(b[i], r);
        end
        put_bit(1'b1, r);
        ack = !r;
    endtask
endmodule

// *** verification/sew_top_tb.sv ***
// self-checking bench for the eeprom slave
`timescale 1ns/100ps
module sew_top_tb;
    import sew_pkg::*;
    localparam int PC = 200;
    localparam int PLC = 400;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic cs_lo = 1'b0;
    logic cs_hi = 1'b0;
    logic wmode = 1'b0;
    logic winh = 1'b0;
    logic pen = 1'b0;
    logic scl, sda_drv, sda_in, sda_out, sda_oe, busy;
    logic [31:0] seed = 32'h39F2D0E5;
    logic [8:0] ta [4] = '{9'h006, 9'h100, 9'h0F8, 9'h105};
    int tn [4] = '{4, 4, 8, 8};
    logic tm [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    int n_errors = 0;
    int n_checks = 0;
    always #5 core_clk = ~core_clk;
    // pulled-up wire: either party may pull it low
    assign sda_in = sda_drv & (sda_oe ? sda_out : 1'b1);
    sew_master u_bus (.scl(scl), .sda_drv(sda_drv), .sda(sda_in));
    sew_top #(.PROG_CYC(PC), .PROG_LONG_CYC(PLC)) u_dut (
        .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .scl(scl),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_low_bit(cs_lo), .chip_select_high_bit(cs_hi),
        .write_mode(wmode), .write_inhibit(winh),
        .protect_enable(pen), .busy(busy));
    // ****
    // helpers
    // ****
    function automatic logic [7:0] rnd();
        seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
        return seed[7:0];
    endfunction
    function automatic logic sel_ok(input logic [7:0] s);
        return s[7:4] == DEV_TYPE_DEF && s[3] == cs_hi && s[2] == cs_lo;
    endfunction
    function automatic logic span_long(input logic [7:0] a, input int n,
        input logic m);
        logic [7:0] e;
        e = a + 8'(n - 1);
        return m && n > 1 && a[7:2] != e[7:2];
    endfunction
    task automatic close_out();
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    // write blocked by inhibit or by the pointer byte p
    function automatic logic blk(input logic [8:0] a, input logic [7:0] p);
        return winh || (pen && !p[2] && a[8] && a[7:3] >= p[7:3]);
    endfunction
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("[ERR] %0t busy length %0d", $time, got);
        end
    endtask
    task automatic tx(input logic [7:0] b, input logic exp);
        logic ack;
        u_bus.put_byte(b, ack);
        chk_bit(ack, exp);
    endtask
    // kind 0 no program, 1 single row, 2 two rows
    task automatic prog(input int kind);
        int t;
        int c;
        t = 0;
        c = 0;
        while (busy !== 1'b1 && t < 40) begin
            @(negedge core_clk);
            t++;
        end
        chk_bit(busy, kind != 0);
        while (busy === 1'b1 && c < 600) begin
            @(negedge core_clk);
            c++;
        end
        if (kind == 1) chk_cnt(c, PC / 2, (PC + PLC) / 2);
        if (kind == 2) chk_cnt(c, (PC + PLC) / 2, PLC + 40);
    endtask
    task automatic wr(input logic [8:0] a, input int n, input logic m,
        input logic [7:0] d0);
        int k;
        @(negedge core_clk);
        wmode = m;
        u_bus.start_c();
        tx({DEV_TYPE_DEF, cs_hi, cs_lo, a[8], 1'b0}, 1'b1);
        tx(a[7:0], 1'b1);
        for (k = 0; k < n; k++) begin
            tx(k == 0 ? d0 : rnd(), 1'b1);
        end
        u_bus.stop_c();
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        logic [7:0] s;
        logic ack;
        logic [8:0] a;
        logic [7:0] d;
        logic [7:0] o;
        logic [7:0] pm;
        int j;
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        s = rnd();
        cs_hi = s[0];
        cs_lo = s[1];
        for (j = 0; j < 8; j++) begin
            s = rnd();
            if (j[0]) s[7:4] = DEV_TYPE_DEF;
            if (j[1]) s[3:2] = {cs_hi, cs_lo};
            if (j == 3) s[0] = 1'b1;
            u_bus.start_c();
            tx(s, sel_ok(s));
            u_bus.stop_c();
            prog(0);
        end
        s = rnd();
        wr({s[0], rnd()}, 0, 1'b0, 8'h00);
        prog(0);
        for (j = 0; j < 2; j++) begin
            s = rnd();
            wr({s[7], rnd()}, 1, j[0], rnd());
            prog(1);
        end
        for (j = 0; j < 4; j++) begin
            wr(ta[j], tn[j], tm[j], rnd());
            prog(span_long(ta[j][7:0], tn[j], tm[j]) ? 2 : 1);
        end
        // array read through u_dut.mem_r: each stored byte is checked after its cycle
        for (j = 0; j < 4; j++) begin
            @(negedge core_clk);
            winh = j[0];
            pen = j[1];
            a = {1'b1, rnd()};
            d = rnd();
            o = u_dut.mem_r[a];
            wr(a, 1, 1'b1, d);
            prog(1);
            chk_byte(u_dut.mem_r[a], blk(a, pm) ? o : d);
            d = rnd() & 8'hF8;
            o = u_dut.mem_r[PTR_ADDR];
            wr(PTR_ADDR, 1, 1'b0, d);
            prog(1);
            pm = blk(PTR_ADDR, pm) ? o : d;
            chk_byte(u_dut.mem_r[PTR_ADDR], pm);
        end
        wr(9'h010, 2, 1'b0, rnd());
        u_bus.start_c();
        tx({DEV_TYPE_DEF, cs_hi, cs_lo, 2'b00}, 1'b0);
        j = 0;
        ack = 1'b0;
        while (ack !== 1'b1 && j < 20) begin
            u_bus.start_c();
            u_bus.put_byte({DEV_TYPE_DEF, cs_hi, cs_lo, 2'b00}, ack);
            j++;
        end
        chk_bit(ack, 1'b1);
        tx(8'h10, 1'b1);
        u_bus.stop_c();
        prog(0);
        close_out();
    end
    initial begin
        #1000000;
        n_errors++;
        close_out();
    end
endmodule
